// ==== pkg/lpw_params.svh ====
`ifndef LPW_PARAMS_SVH
`define LPW_PARAMS_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define LPW_CNT_W          18
`define LPW_QUAL_W         6

// ----------------------------------------------------------------
// timing counts, system clock cycles unless noted
// ----------------------------------------------------------------
`define LPW_FLUSH_SHORT    32
`define LPW_FLUSH_LONG     64
`define LPW_EXT_LOW_MIN    32
`define LPW_EXT_LOW_MAX    45
`define LPW_STBY_FAST      100
`define LPW_FLASH_SLOW     1125
`define LPW_HALT_RAM       35
`define LPW_RESUME_MARGIN  4
`define LPW_QUAL_BASE      2
// oscillator cycles, counted on the system clock here
`define LPW_PLL_LOCK_CYC   131072

`endif

// ==== pkg/lpw_pkg.sv ====
package lpw_pkg;

   // ----------------------------------------------------------------
   // sequencer states, gray in the order declared
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      LPW_RUN        = 3'h0,
      LPW_FLUSH      = 3'h1,
      LPW_SLEEP_STBY = 3'h3,
      LPW_SLEEP_HALT = 3'h2,
      LPW_OSC_WAIT   = 3'h6,
      LPW_PLL_LOCK   = 3'h7,
      LPW_RESUME     = 3'h5
   } lpw_state_type;

   // ----------------------------------------------------------------
   // software settings seen by the sequencer
   // ----------------------------------------------------------------
   typedef struct packed {
      logic       lp_halt;
      logic       input_clk_div_sel;
      logic       qual_en;
      logic [5:0] standby_qual_count;
      logic       flash_sleep;
      logic       wake_int_en;
   } lpw_cfg_type;

   // ----------------------------------------------------------------
   // clock and power gates, 1 = running
   // ----------------------------------------------------------------
   typedef struct packed {
      logic sys_clk_en;
      logic periph_clk_en;
      logic ext_clk_en;
      logic wdog_clk_en;
      logic pll_on;
   } lpw_gate_type;

   typedef struct packed {
      lpw_state_type st;
      logic [17:0]   cnt;
      logic          halt_sel;
      logic          div_sel;
      logic          flash_sel;
      logic          irq_en_sel;
      lpw_gate_type  gate;
      logic          resume;
      logic          wake_irq;
      logic          irq_pend;
      logic [1:0]    stable_sync;
   } lpw_core_type;

endpackage

// ==== hdl/lpw_osc_latch.sv ====
`timescale 1ns/1ps
`include "lpw_params.svh"

module lpw_osc_latch (
   // clock and reset
   input  wire logic sys_clk_i,
   input  wire logic rst_i,
   input  wire logic ce_i,
   // wake pin, raw and active low
   input  wire logic wake_gpio_n_i,
   // control and status
   input  wire logic osc_stop_i,
   output logic      osc_on_o,
   output logic      wake_n_sync_o
);

   logic [1:0] sync_q;

   // ----------------------------------------------------------------
   // oscillator run flag, set by the pin edge with no clock running
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_i or posedge rst_i
               or negedge wake_gpio_n_i) begin
      if (rst_i) begin
         osc_on_o <= 1'b1;
      end else if (!wake_gpio_n_i) begin
         osc_on_o <= 1'b1;
      end else if (ce_i && osc_stop_i) begin
         osc_on_o <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // two-stage synchroniser for the wake pin
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         sync_q <= 2'h3;
      end else if (ce_i) begin
         sync_q <= {sync_q[0], wake_gpio_n_i};
      end
   end

   assign wake_n_sync_o = sync_q[1];

   wake_sets_osc_a: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      !wake_gpio_n_i |-> osc_on_o)
      else $error("oscillator not running while wake pin low");

endmodule

// ==== hdl/lpw_sequencer.sv ====
// What this block does
// - the external clock goes low 32 to 45 cycles after idle.
// - standby resume within 100 cycles, or 1125 from sleeping flash.
// - latency ends at the next instruction; the interrupt comes later.
// - standby entry keeps the system clock 32 or 64 cycles by divide.
// - standby stops peripheral clocks but keeps the PLL and watchdog.
// - a standby wake resumes after a latency, interrupt only if enabled.
// - halt entry keeps the clock 32 or 64 cycles, then stops osc and core.
// - halt stops peripheral clocks, the PLL and the oscillator.
// - a falling wake pin edge restarts the oscillator with no clock.
// - a halt wake always counts PLL_LOCK_CYC cycles, 131072 by default, for PLL lock.
// - after lock, halt resume within 1125 cycles from flash, 35 from RAM.
// - leaving halt turns clocks back on, then the interrupt if enabled.
`timescale 1ns/1ps
`include "lpw_params.svh"

module lpw_sequencer #(
   parameter int PLL_LOCK_CYC = `LPW_PLL_LOCK_CYC
) (
   // clock, reset, enable
   input  wire logic              sys_clk_i,
   input  wire logic              rst_i,
   input  wire logic              ce_i,
   // core side
   input  wire logic              idle_exec_i,
   input  wire logic              bus_busy_i,
   input  wire lpw_pkg::lpw_cfg_type cfg_i,
   // pins and oscillator
   input  wire logic              wake_gpio_n_i,
   input  wire logic              osc_stable_i,
   // clock gates and status
   output lpw_pkg::lpw_gate_type  gate_o,
   output logic                   osc_on_o,
   output logic                   resume_o,
   output logic                   wake_irq_o,
   output lpw_pkg::lpw_state_type state_o
);

   localparam logic [17:0] LOCK_LAST = 18'(PLL_LOCK_CYC - 1);

   lpw_pkg::lpw_core_type s_q;
   lpw_pkg::lpw_core_type s_d;
   logic                  wake_n_sync;
   logic                  osc_stop;
   logic [17:0]           flush_last;
   logic [17:0]           resume_last;
   logic [17:0]           qual_last;

   // ----------------------------------------------------------------
   // oscillator latch and wake synchroniser
   // ----------------------------------------------------------------
   assign osc_stop = (s_q.st == lpw_pkg::LPW_SLEEP_HALT);

   lpw_osc_latch u_osc (
      .sys_clk_i     (sys_clk_i),
      .rst_i         (rst_i),
      .ce_i          (ce_i),
      .wake_gpio_n_i (wake_gpio_n_i),
      .osc_stop_i    (osc_stop),
      .osc_on_o      (osc_on_o),
      .wake_n_sync_o (wake_n_sync)
   );

   // ----------------------------------------------------------------
   // derived limits
   // ----------------------------------------------------------------
   always_comb begin
      flush_last = s_q.div_sel ? 18'(`LPW_FLUSH_LONG - 1)
                               : 18'(`LPW_FLUSH_SHORT - 1);
      qual_last = 18'(cfg_i.standby_qual_count)
                + 18'(`LPW_QUAL_BASE - 1);
      if (s_q.flash_sel) begin
         resume_last = 18'(`LPW_FLASH_SLOW - `LPW_RESUME_MARGIN);
      end else if (s_q.halt_sel) begin
         resume_last = 18'(`LPW_HALT_RAM - `LPW_RESUME_MARGIN);
      end else begin
         resume_last = 18'(`LPW_STBY_FAST - `LPW_RESUME_MARGIN);
      end
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.resume = 1'b0;
      s_d.wake_irq = 1'b0;
      s_d.stable_sync = {s_q.stable_sync[0], osc_stable_i};
      s_d.cnt = s_q.cnt + 18'h00001;
      if (s_q.irq_pend) begin
         s_d.wake_irq = 1'b1;
         s_d.irq_pend = 1'b0;
      end
      case (s_q.st)
         lpw_pkg::LPW_RUN: begin
            s_d.cnt = 18'h00000;
            if (idle_exec_i) begin
               s_d.st = lpw_pkg::LPW_FLUSH;
               s_d.halt_sel = cfg_i.lp_halt;
               s_d.div_sel = cfg_i.input_clk_div_sel;
               s_d.flash_sel = cfg_i.flash_sleep;
               s_d.irq_en_sel = cfg_i.wake_int_en;
            end
         end
         lpw_pkg::LPW_FLUSH: begin
            if (s_q.cnt == 18'(`LPW_EXT_LOW_MIN - 1)) begin
               s_d.gate.ext_clk_en = 1'b0;
            end
            if (s_q.cnt >= flush_last) begin
               s_d.cnt = s_q.cnt;
               if (!bus_busy_i) begin
                  s_d.cnt = 18'h00000;
                  s_d.gate.sys_clk_en = 1'b0;
                  s_d.gate.periph_clk_en = 1'b0;
                  s_d.gate.ext_clk_en = 1'b0;
                  if (s_q.halt_sel) begin
                     s_d.st = lpw_pkg::LPW_SLEEP_HALT;
                     s_d.gate.pll_on = 1'b0;
                     s_d.gate.wdog_clk_en = 1'b0;
                  end else begin
                     s_d.st = lpw_pkg::LPW_SLEEP_STBY;
                  end
               end
            end
         end
         lpw_pkg::LPW_SLEEP_STBY: begin
            if (wake_n_sync) begin
               s_d.cnt = 18'h00000;
            end else if (!cfg_i.qual_en || s_q.cnt >= qual_last) begin
               s_d.st = lpw_pkg::LPW_RESUME;
               s_d.cnt = 18'h00000;
               s_d.gate.sys_clk_en = 1'b1;
               s_d.gate.periph_clk_en = 1'b1;
               s_d.gate.ext_clk_en = 1'b1;
            end
         end
         lpw_pkg::LPW_SLEEP_HALT: begin
            s_d.cnt = 18'h00000;
            if (!wake_n_sync) begin
               s_d.st = lpw_pkg::LPW_OSC_WAIT;
            end
         end
         lpw_pkg::LPW_OSC_WAIT: begin
            s_d.cnt = 18'h00000;
            if (s_q.stable_sync[1] && osc_on_o) begin
               s_d.st = lpw_pkg::LPW_PLL_LOCK;
               s_d.gate.pll_on = 1'b1;
               s_d.gate.wdog_clk_en = 1'b1;
            end
         end
         lpw_pkg::LPW_PLL_LOCK: begin
            if (s_q.cnt >= LOCK_LAST) begin
               s_d.st = lpw_pkg::LPW_RESUME;
               s_d.cnt = 18'h00000;
               s_d.gate.sys_clk_en = 1'b1;
               s_d.gate.periph_clk_en = 1'b1;
               s_d.gate.ext_clk_en = 1'b1;
            end
         end
         lpw_pkg::LPW_RESUME: begin
            if (s_q.cnt >= resume_last) begin
               s_d.st = lpw_pkg::LPW_RUN;
               s_d.cnt = 18'h00000;
               s_d.resume = 1'b1;
               s_d.irq_pend = s_q.irq_en_sel;
            end
         end
         default: begin
            s_d.st = lpw_pkg::LPW_RUN;
            s_d.cnt = 18'h00000;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_q <= '{st: lpw_pkg::LPW_RUN, cnt: 18'h00000,
                  gate: 5'h1F, stable_sync: 2'h0, default: 1'b0};
      end else if (ce_i) begin
         s_q <= s_d;
      end
   end

   assign gate_o = s_q.gate;
   assign resume_o = s_q.resume;
   assign wake_irq_o = s_q.wake_irq;
   assign state_o = s_q.st;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);

   logic [17:0] since_idle_q;
   logic [17:0] since_wake_q;

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         since_idle_q <= 18'h00000;
         since_wake_q <= 18'h00000;
      end else if (ce_i) begin
         since_idle_q <= (s_q.st == lpw_pkg::LPW_RUN) ? 18'h00000
                       : since_idle_q + 18'h00001;
         since_wake_q <= (s_q.st == lpw_pkg::LPW_SLEEP_STBY) ? 18'h00000
                       : since_wake_q + 18'h00001;
      end
   end

   ext_low_time_a: assert property (
      $fell(gate_o.ext_clk_en)
      |-> since_idle_q >= 18'(`LPW_EXT_LOW_MIN)
          && since_idle_q <= 18'(`LPW_EXT_LOW_MAX))
      else $error("external clock gated outside 32..45 cycles");

   flush_clock_on_a: assert property (
      s_q.st == lpw_pkg::LPW_FLUSH |-> gate_o.sys_clk_en)
      else $error("system clock gated during flush");

   flush_length_a: assert property (
      $fell(gate_o.sys_clk_en) |->
      since_idle_q >= (s_q.div_sel ? 18'(`LPW_FLUSH_LONG)
                                   : 18'(`LPW_FLUSH_SHORT)))
      else $error("flush shorter than divide select asks");

   standby_gates_a: assert property (
      s_q.st == lpw_pkg::LPW_SLEEP_STBY |->
      !gate_o.periph_clk_en && gate_o.pll_on && gate_o.wdog_clk_en)
      else $error("standby gating wrong");

   halt_gates_a: assert property (
      s_q.st == lpw_pkg::LPW_SLEEP_HALT |->
      !gate_o.periph_clk_en && !gate_o.pll_on && !gate_o.sys_clk_en)
      else $error("halt gating wrong");

   bus_hold_a: assert property (
      s_q.st == lpw_pkg::LPW_FLUSH && bus_busy_i && ce_i
      |=> gate_o.sys_clk_en)
      else $error("clock gated with bus busy");

   lock_length_a: assert property (
      $rose(s_q.st == lpw_pkg::LPW_RESUME) && s_q.halt_sel
      |-> $past(s_q.cnt) == LOCK_LAST)
      else $error("pll lock count wrong");

   standby_resume_a: assert property (
      resume_o && !s_q.halt_sel |->
      since_wake_q < (s_q.flash_sel ? 18'(`LPW_FLASH_SLOW)
                                    : 18'(`LPW_STBY_FAST)))
      else $error("standby resume too late");

   irq_follow_a: assert property (
      resume_o && ce_i |=> (wake_irq_o == s_q.irq_en_sel))
      else $error("wake interrupt not as enabled");

   mode_pick_a: assert property (
      s_q.st == lpw_pkg::LPW_RUN && idle_exec_i && ce_i
      |=> s_q.halt_sel == $past(cfg_i.lp_halt))
      else $error("low power mode not sampled at idle");

   standby_wake_c: cover property (
      s_q.st == lpw_pkg::LPW_SLEEP_STBY ##[1:1000] resume_o);
   halt_wake_c: cover property (
      s_q.st == lpw_pkg::LPW_OSC_WAIT ##1 s_q.st == lpw_pkg::LPW_PLL_LOCK);
   irq_c: cover property (resume_o ##1 wake_irq_o);

endmodule

// ==== bench/lpw_wake_src.sv ====
`timescale 1ns/1ps

module lpw_wake_src #(
   parameter int OSC_START = 6
) (
   // clock
   input  wire logic sys_clk_i,
   // oscillator run request from the sequencer
   input  wire logic osc_on_i,
   // wake pin and oscillator status
   output logic      wake_gpio_n_o,
   output logic      osc_stable_o
);
   int run_q;

   // ----------------------------------------------------------------
   // oscillator start-up, lost as soon as it is stopped
   // ----------------------------------------------------------------
   always @(posedge sys_clk_i or negedge osc_on_i) begin
      if (!osc_on_i)
         run_q <= 0;
      else if (run_q < OSC_START)
         run_q <= run_q + 1;
   end

   assign osc_stable_o = osc_on_i && (run_q >= OSC_START);

   initial wake_gpio_n_o = 1'b1;

   // ----------------------------------------------------------------
   // wake pulse: fixed length, or held until the oscillator is stable
   // ----------------------------------------------------------------
   task automatic pulse(input int low_cyc, input bit to_stable);
      int n;
      n = 0;
      @(posedge sys_clk_i);
      #10 wake_gpio_n_o = 1'b0;
      while (to_stable && !osc_stable_o && n < 2000) begin
         @(posedge sys_clk_i);
         n++;
      end
      repeat (to_stable ? 2 : low_cyc) @(posedge sys_clk_i);
      #10 wake_gpio_n_o = 1'b1;
   endtask
endmodule

// ==== bench/test_low_power_wake_sequencer.sv ====
`timescale 1ns/1ps

`define CHK(nm, exp, got) begin \
   comparisons++; \
   if ((got) !== (exp)) begin \
      bad_count++; \
      $display("[FAIL] %s exp %0h got %0h", nm, exp, got); \
   end \
end

module test_low_power_wake_sequencer;
   typedef struct packed {
      logic [3:0]  sel;
      logic [7:0]  sys_off;
      logic [11:0] limit;
   } lpw_row_type;

   logic                   sys_clk_i   = 1'b0;
   logic                   rst_i       = 1'b1;
   logic                   idle        = 1'b0;
   logic                   busy        = 1'b0;
   lpw_pkg::lpw_cfg_type   cfg         = 11'h000;
   logic                   wake_n;
   logic                   osc_st;
   logic                   osc_on;
   logic                   resume;
   logic                   irq;
   lpw_pkg::lpw_gate_type  gate;
   lpw_pkg::lpw_state_type st;
   int                     bad_count   = 0;
   int                     comparisons = 0;
   // sel is {halt, div, flash_sleep, irq_en}
   lpw_row_type            rows [4]    = '{'{4'h1, 8'h20, 12'h064},
                                           '{4'h6, 8'h40, 12'h465},
                                           '{4'h8, 8'h20, 12'h023},
                                           '{4'hF, 8'h40, 12'h465}};

   always #50 sys_clk_i = ~sys_clk_i;

   lpw_sequencer #(.PLL_LOCK_CYC(16)) dut_u (
      .sys_clk_i    (sys_clk_i),
      .rst_i        (rst_i),
      .ce_i         (1'b1),
      .idle_exec_i  (idle),
      .bus_busy_i   (busy),
      .cfg_i        (cfg),
      .wake_gpio_n_i(wake_n),
      .osc_stable_i (osc_st),
      .gate_o       (gate),
      .osc_on_o     (osc_on),
      .resume_o     (resume),
      .wake_irq_o   (irq),
      .state_o      (st)
   );

   lpw_wake_src src_u (
      .sys_clk_i    (sys_clk_i),
      .osc_on_i     (osc_on),
      .wake_gpio_n_o(wake_n),
      .osc_stable_o (osc_st)
   );

   task automatic tick(input int c);
      repeat (c) begin
         @(posedge sys_clk_i);
         #10;
      end
   endtask

   // ----------------------------------------------------------------
   // idle entry and sleep state
   // ----------------------------------------------------------------
   task automatic enter(input logic [3:0] s, input logic [7:0] sys_exp);
      int ne;
      int ns;
      ne = 0;
      ns = 0;
      cfg.lp_halt = s[3];
      cfg.input_clk_div_sel = s[2];
      cfg.flash_sleep = s[1];
      cfg.wake_int_en = s[0];
      idle = 1'b1;
      tick(1);
      idle = 1'b0;
      for (int i = 1; i <= 200 && ns == 0; i++) begin
         tick(1);
         if (ne == 0 && gate.ext_clk_en !== 1'b1)
            ne = i;
         if (gate.sys_clk_en !== 1'b1)
            ns = i;
      end
      `CHK("ext_low", 1'b1, ne >= 32 && ne <= 45)
      `CHK("sys_off", 1'b1, ns >= sys_exp && ns <= sys_exp + 2)
      tick(2);
      `CHK("periph", 1'b0, gate.periph_clk_en)
      `CHK("pll", ~s[3], gate.pll_on)
      `CHK("wdog", ~s[3], gate.wdog_clk_en)
      `CHK("osc", ~s[3], osc_on)
      idle = 1'b1;
      tick(1);
      idle = 1'b0;
      tick(1);
      `CHK("state", s[3] ? lpw_pkg::LPW_SLEEP_HALT : lpw_pkg::LPW_SLEEP_STBY, st)
   endtask

   // ----------------------------------------------------------------
   // wake and resume latency
   // ----------------------------------------------------------------
   task automatic leave(input logic [3:0] s, input logic [11:0] lim,
                        input int low);
      int n;
      int k;
      n = 0;
      k = 0;
      fork
         src_u.pulse(low, s[3]);
         begin
            @(posedge sys_clk_i);
            #11;
            if (s[3]) begin
               `CHK("osc_async", 1'b1, osc_on)
               while (st !== lpw_pkg::LPW_PLL_LOCK && n < 100) begin
                  tick(1);
                  n++;
               end
               while (st === lpw_pkg::LPW_PLL_LOCK && k < 100) begin
                  tick(1);
                  k++;
               end
               `CHK("lock_len", 16, k)
               n = 0;
            end
            while (resume !== 1'b1 && n < 2000) begin
               tick(1);
               n++;
            end
         end
      join
      `CHK("resume_time", 1'b1, n <= lim)
      `CHK("gates_on", 1'b1, gate.sys_clk_en & gate.periph_clk_en & gate.pll_on)
      `CHK("irq_early", 1'b0, irq)
      tick(1);
      `CHK("wake_irq", s[0], irq)
   endtask

   task automatic conclude;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial begin
      #2000000;
      bad_count++;
      conclude();
   end

   initial begin
      repeat (12) @(posedge sys_clk_i);
      #10;
      `CHK("rst_gate", 5'h1F, gate)
      `CHK("rst_state", lpw_pkg::LPW_RUN, st)
      `CHK("rst_resume", 1'b0, resume)
      rst_i = 1'b0;
      tick(1);
      `CHK("rel_gate", 5'h1F, gate)
      $display("test reset done");
      foreach (rows[i]) begin
         enter(rows[i].sel, rows[i].sys_off);
         leave(rows[i].sel, rows[i].limit, 3);
         tick(2);
         $display("test row %0d done", i);
      end
      cfg.qual_en = 1'b1;
      cfg.standby_qual_count = 6'h03;
      enter(4'h1, 8'h20);
      src_u.pulse(4, 1'b0);
      tick(20);
      `CHK("glitch", lpw_pkg::LPW_SLEEP_STBY, st)
      leave(4'h1, 12'h069, 8);
      cfg.qual_en = 1'b0;
      tick(2);
      $display("test qualification done");
      busy = 1'b1;
      fork
         begin
            tick(50);
            busy = 1'b0;
         end
         enter(4'h1, 8'h32);
      join
      leave(4'h1, 12'h064, 3);
      tick(2);
      $display("test bus stall done");
      cfg.lp_halt = 1'b1;
      idle = 1'b1;
      tick(1);
      idle = 1'b0;
      tick(40);
      rst_i = 1'b1;
      tick(1);
      `CHK("mid_gate", 5'h1F, gate)
      `CHK("mid_osc", 1'b1, osc_on)
      `CHK("mid_state", lpw_pkg::LPW_RUN, st)
      rst_i = 1'b0;
      tick(2);
      `CHK("rel2_state", lpw_pkg::LPW_RUN, st)
      `CHK("rel2_gate", 5'h1F, gate)
      `CHK("rel2_osc", 1'b1, osc_on)
      $display("test mid reset done");
      conclude();
   end
endmodule
